// ===== src/lmbs_top.sv
/*
 * Brightness and shutdown logic of a 39 x 9 LED matrix driver: per-LED
 * 256-step PWM codes, anti-ghost pull control, software and hardware
 * shutdown, and a register port facing the serial interface.
 * Assumes core_clk_i at 50 MHz, scan_clk_i free running and unrelated,
 * and a shutdown pin that is asynchronous to both clocks.
 */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lmbs_regs.svh"

module lmbs_top
    import lmbs_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 scan_clk_i,
    input  wire logic                 hw_shutdown_pin_n_i,
    input  wire lmbs_pkg::lmbs_addr_t reg_addr_i,
    input  wire lmbs_pkg::lmbs_byte_t reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output var  lmbs_pkg::lmbs_byte_t reg_rdata_o,
    output var  logic                 serial_reset_o,
    output var  logic                 analog_en_o,
    output var  logic [2:0]           row_pulldown_sel_o,
    output var  logic [2:0]           column_pullup_sel_o,
    output var  logic [8:0]           row_switch_out_o,
    output var  logic [38:0]          column_current_sink_o,
    output var  logic [8:0]           row_pulldown_en_o,
    output var  logic [38:0]          column_pullup_en_o
);
    import lmbs_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Flat LED index of a row and column
    function automatic lmbs_idx_t led_index(input lmbs_row_t row, input lmbs_idx_t col);
        logic [12:0] prod;
        prod = 13'(row) * 13'(`LMBS_COLS_W) + 13'(col);
        return prod[8:0];
    endfunction

    // ------------------------------------------------------------------
    // Core domain: shutdown pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic sdb_meta_reg;
    logic sdb_sync_reg;
    logic sdb_prev_reg;
    logic sdb_rise;

    // Two flops before any logic looks at the pin
    always_ff @(posedge core_clk_i) begin
        sdb_meta_reg <= hw_shutdown_pin_n_i;
        sdb_sync_reg <= sdb_meta_reg;
    end

    // Previous sample for the rising-edge detector; resets to the pin's idle
    // high level so that no false edge follows the release of reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sdb_prev_reg <= 1'b1;
        end else begin
            sdb_prev_reg <= sdb_sync_reg;
        end
    end

    assign sdb_rise = sdb_sync_reg & ~sdb_prev_reg;

    // ------------------------------------------------------------------
    // Core domain: register storage
    // ------------------------------------------------------------------
    lmbs_byte_t pwm_mem [`LMBS_LEDS];
    lmbs_byte_t config_reg;
    lmbs_byte_t pull_reg;
    lmbs_byte_t rdata_reg;
    lmbs_byte_t rdata_next;
    logic       serial_reset_reg;
    logic       analog_en_reg;

    logic       hit_pwm;
    logic       hit_config;
    logic       hit_pull;
    logic       hit_status;
    lmbs_idx_t  pwm_widx;
    lmbs_byte_t status_val;

    // Address decode
    assign hit_pwm    = (reg_addr_i <= `LMBS_OFF_PWM_LAST);
    assign hit_config = (reg_addr_i == `LMBS_OFF_CONFIG);
    assign hit_pull   = (reg_addr_i == `LMBS_OFF_PULL);
    assign hit_status = (reg_addr_i == `LMBS_OFF_STATUS);
    assign pwm_widx   = reg_addr_i[8:0];

    // Status shows the live shutdown states
    always_comb begin
        status_val = `LMBS_RD_IDLE;
        status_val[`LMBS_ST_HWSD_BIT] = ~sdb_sync_reg;
        status_val[`LMBS_ST_SSD_BIT]  = ~config_reg[`LMBS_CFG_SSD_BIT];
    end

    // Read mux; unmapped offsets read zero
    assign rdata_next = (!reg_rd_i)  ? `LMBS_RD_IDLE :
                        hit_pwm      ? pwm_mem[pwm_widx] :
                        hit_config   ? config_reg :
                        hit_pull     ? pull_reg :
                        hit_status   ? status_val :
                                       `LMBS_RD_IDLE;

    // PWM codes: written in every power state, never cleared by shutdown
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `LMBS_LEDS; i++) begin
                pwm_mem[i] <= `LMBS_PWM_RST;
            end
        end else if (reg_wr_i && hit_pwm) begin
            pwm_mem[pwm_widx] <= reg_wdata_i;
        end
    end

    // Configuration and pull selection registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            config_reg <= `LMBS_CONFIG_RST;
            pull_reg   <= `LMBS_PULL_RST;
        end else if (reg_wr_i) begin
            if (hit_config) begin
                config_reg <= reg_wdata_i;
            end
            if (hit_pull) begin
                pull_reg <= reg_wdata_i & `LMBS_PULL_MASK;
            end
        end
    end

    // Read data stands for one cycle; a pin rising edge drops a pending answer
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= `LMBS_RD_IDLE;
        end else if (sdb_rise) begin
            rdata_reg <= `LMBS_RD_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Serial interface reset pulse and analog enable
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            serial_reset_reg <= 1'b0;
            analog_en_reg    <= 1'b0;
        end else begin
            serial_reset_reg <= sdb_rise;
            analog_en_reg    <= sdb_sync_reg;
        end
    end

    assign reg_rdata_o         = rdata_reg;
    assign serial_reset_o      = serial_reset_reg;
    assign analog_en_o         = analog_en_reg;
    assign row_pulldown_sel_o  = pull_reg[`LMBS_ROW_SEL_MSB:`LMBS_ROW_SEL_LSB];
    assign column_pullup_sel_o = pull_reg[`LMBS_COL_SEL_MSB:`LMBS_COL_SEL_LSB];

    // ------------------------------------------------------------------
    // Scan domain: level crossings
    // ------------------------------------------------------------------
    logic [4:0] lvl_src;
    logic [4:0] lvl_meta_reg;
    logic [4:0] lvl_sync_reg;
    logic       scan_rst_n;
    logic       blank;
    logic       hwsd;
    logic       row_pull_on;
    logic       col_pull_on;

    // Reset, soft shutdown, pull-enable levels from the core domain, and the shutdown pin itself
    assign lvl_src[0] = rst_n_i;
    assign lvl_src[1] = config_reg[`LMBS_CFG_SSD_BIT];
    assign lvl_src[2] = (pull_reg[`LMBS_ROW_SEL_MSB:`LMBS_ROW_SEL_LSB] != `LMBS_SEL_NONE);
    assign lvl_src[3] = (pull_reg[`LMBS_COL_SEL_MSB:`LMBS_COL_SEL_LSB] != `LMBS_SEL_NONE);
    assign lvl_src[4] = hw_shutdown_pin_n_i;

    // Every level passes two flops; only the second is read
    always_ff @(posedge scan_clk_i) begin
        lvl_meta_reg <= lvl_src;
        lvl_sync_reg <= lvl_meta_reg;
    end

    assign scan_rst_n  = lvl_sync_reg[0];
    assign hwsd        = ~lvl_sync_reg[4];
    assign blank       = ~lvl_sync_reg[1] | hwsd;
    assign row_pull_on = lvl_sync_reg[2] & ~hwsd;
    assign col_pull_on = lvl_sync_reg[3] & ~hwsd;

    // ------------------------------------------------------------------
    // Scan domain: row scan and PWM counter
    // ------------------------------------------------------------------
    lmbs_scan_e state_reg;
    lmbs_scan_e state_next;
    lmbs_row_t  row_reg;
    lmbs_row_t  row_next;
    lmbs_byte_t cnt_reg;
    lmbs_byte_t cnt_next;

    // One blank cycle between rows, then 256 PWM counts per row
    always_comb begin
        state_next = state_reg;
        row_next   = row_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            SCAN_BLANK: begin
                state_next = SCAN_DRIVE;
                cnt_next   = `LMBS_CNT_FIRST;
            end
            SCAN_DRIVE: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == `LMBS_CNT_LAST) begin
                    state_next = SCAN_BLANK;
                    row_next   = (row_reg == `LMBS_ROW_LAST) ? `LMBS_ROW_FIRST
                                                              : row_reg + 4'h1;
                end
            end
            default: begin
                state_next = SCAN_BLANK;
            end
        endcase
    end

    // Scan state registers
    always_ff @(posedge scan_clk_i) begin
        if (!scan_rst_n) begin
            state_reg <= SCAN_BLANK;
            row_reg   <= `LMBS_ROW_FIRST;
            cnt_reg   <= `LMBS_CNT_FIRST;
        end else begin
            state_reg <= state_next;
            row_reg   <= row_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Scan domain: drive and pull outputs
    // ------------------------------------------------------------------
    logic        drive;
    logic [8:0]  row_on;
    logic [38:0] col_on;
    logic [8:0]  row_on_reg;
    logic [38:0] col_on_reg;
    logic [8:0]  row_pd_reg;
    logic [38:0] col_pu_reg;

    assign drive = (state_reg == SCAN_DRIVE) & ~blank;

    // Row switch conducts only for the row being scanned
    generate
        for (genvar r = 0; r < `LMBS_ROWS; r++) begin : g_row
            assign row_on[r] = drive & (row_reg == 4'(r));
        end
    endgenerate

    // A code of N keeps the sink on for N of 256 counts; codes change slowly,
    // so the core-written memory is read here without a handshake
    generate
        for (genvar c = 0; c < `LMBS_COLS; c++) begin : g_col
            assign col_on[c] = drive &
                               (pwm_mem[led_index(row_reg, 9'(c))] > cnt_reg);
        end
    endgenerate

    // Outputs and pulls registered together so a pull never overlaps conduction
    always_ff @(posedge scan_clk_i) begin
        if (!scan_rst_n) begin
            row_on_reg <= '0;
            col_on_reg <= '0;
            row_pd_reg <= '0;
            col_pu_reg <= '0;
        end else begin
            row_on_reg <= row_on;
            col_on_reg <= col_on;
            row_pd_reg <= ~row_on & {`LMBS_ROWS{row_pull_on}};
            col_pu_reg <= ~col_on & {`LMBS_COLS{col_pull_on}};
        end
    end

    assign row_switch_out_o      = row_on_reg;
    assign column_current_sink_o = col_on_reg;
    assign row_pulldown_en_o     = row_pd_reg;
    assign column_pullup_en_o    = col_pu_reg;

endmodule
`default_nettype wire

// ===== src/lmbs_regs.svh
/*
 * Register offsets, field positions, reset values and scan counts of the
 * LED matrix brightness and shutdown block.
 * Assumes a 10-bit word address on the register port.
 */
`ifndef LMBS_REGS_SVH
`define LMBS_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LMBS_OFF_PWM_FIRST 10'h000
`define LMBS_OFF_PWM_LAST  10'h15e
`define LMBS_OFF_CONFIG    10'h200
`define LMBS_OFF_PULL      10'h202
`define LMBS_OFF_STATUS    10'h204

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define LMBS_CONFIG_RST    8'h00
`define LMBS_PULL_RST      8'h55
`define LMBS_PULL_MASK     8'h77
`define LMBS_PWM_RST       8'h00
`define LMBS_RD_IDLE       8'h00
`define LMBS_CFG_SSD_BIT   0
`define LMBS_ROW_SEL_MSB   6
`define LMBS_ROW_SEL_LSB   4
`define LMBS_COL_SEL_MSB   2
`define LMBS_COL_SEL_LSB   0
`define LMBS_SEL_NONE      3'h0
`define LMBS_ST_HWSD_BIT   0
`define LMBS_ST_SSD_BIT    1

// ----------------------------------------------------------------------
// Matrix and scan counts
// ----------------------------------------------------------------------
`define LMBS_ROWS          9
`define LMBS_COLS          39
`define LMBS_LEDS          351
`define LMBS_COLS_W        9'h027
`define LMBS_ROW_FIRST     4'h0
`define LMBS_ROW_LAST      4'h8
`define LMBS_CNT_FIRST     8'h00
`define LMBS_CNT_LAST      8'hff

`endif

// ===== src/lmbs_pkg.sv
/*
 * Types shared by the LED matrix brightness and shutdown block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lmbs_pkg;
    typedef logic [7:0] lmbs_byte_t;
    typedef logic [9:0] lmbs_addr_t;
    typedef logic [3:0] lmbs_row_t;
    typedef logic [8:0] lmbs_idx_t;
    typedef enum logic [0:0] {
        SCAN_BLANK,
        SCAN_DRIVE
    } lmbs_scan_e;
endpackage

// ===== tb/lmbs_host_model.sv
/* Host model: register port master with a short breathing sequencer.
   Assumes core_clk_i drives it and the block never stalls a request. */
`timescale 1ns/1ps
`default_nettype none
module lmbs_host_model
    import lmbs_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire lmbs_pkg::lmbs_byte_t reg_rdata_i,
    output var  lmbs_pkg::lmbs_addr_t reg_addr_o,
    output var  lmbs_pkg::lmbs_byte_t reg_wdata_o,
    output var  logic                 reg_wr_o,
    output var  logic                 reg_rd_o
);
    // Opening entries of the 32-step curve, as used for a short breath
    localparam lmbs_byte_t GAMMA [8] = '{8'h00, 8'h01, 8'h02, 8'h04,
                                         8'h06, 8'h0a, 8'h0d, 8'h12};
    // Opening entries of the 64-step curve, for a slower, smoother breath
    localparam lmbs_byte_t GAMMA_FINE [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                                              8'h04, 8'h05, 8'h06, 8'h07};
    // Idle bus at time zero
    initial begin
        reg_addr_o  = 10'h000;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // One-cycle write; address and data scrambled once released
    task automatic wr(input lmbs_addr_t a, input lmbs_byte_t v);
        @(posedge core_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= v;
        reg_wr_o    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~v;
    endtask
    // One-cycle read; the answer stands in the following cycle only
    task automatic rd(input lmbs_addr_t a, output lmbs_byte_t v);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge core_clk_i);
        v = reg_rdata_i;
    endtask
    // Step up to the top entry and back to zero, one write per step
    task automatic breathe(input lmbs_addr_t a, input logic fine);
        for (int i = 0; i < 16; i++) begin
            wr(a, fine ? GAMMA_FINE[i < 8 ? i : 15 - i] : GAMMA[i < 8 ? i : 15 - i]);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/lmbs_checker.sv
/* Checker: timing relations on the ports of lmbs_top.
   Assumes it is bound into lmbs_top; rst_n_i also gates the scan side. */
`timescale 1ns/1ps
`default_nettype none
`include "lmbs_regs.svh"
module lmbs_checker
    import lmbs_pkg::*;
(
    input wire logic                 core_clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 scan_clk_i,
    input wire logic                 hw_shutdown_pin_n_i,
    input wire lmbs_pkg::lmbs_addr_t reg_addr_i,
    input wire lmbs_pkg::lmbs_byte_t reg_wdata_i,
    input wire logic                 reg_wr_i,
    input wire logic                 reg_rd_i,
    input wire lmbs_pkg::lmbs_byte_t reg_rdata_o,
    input wire logic                 serial_reset_o,
    input wire logic                 analog_en_o,
    input wire logic [2:0]           row_pulldown_sel_o,
    input wire logic [2:0]           column_pullup_sel_o,
    input wire logic [8:0]           row_switch_out_o,
    input wire logic [38:0]          column_current_sink_o,
    input wire logic [8:0]           row_pulldown_en_o,
    input wire logic [38:0]          column_pullup_en_o
);
    // Steps of a pull write, of a pin release and of a pull read
    sequence s_pull_wr;
        reg_wr_i && reg_addr_i == `LMBS_OFF_PULL;
    endsequence
    sequence s_pin_rise;
        !hw_shutdown_pin_n_i ##1 hw_shutdown_pin_n_i;
    endsequence
    sequence s_pull_rd;
        reg_rd_i && reg_addr_i == `LMBS_OFF_PULL;
    endsequence
    property p_sel;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_pull_wr |=>
            row_pulldown_sel_o == $past(reg_wdata_i[`LMBS_ROW_SEL_MSB:`LMBS_ROW_SEL_LSB])
            && column_pullup_sel_o == $past(reg_wdata_i[`LMBS_COL_SEL_MSB:`LMBS_COL_SEL_LSB]);
    endproperty
    a_sel_follows_write:
        assert property (p_sel) else $error("pull select differs from write");
    a_pull_read_back:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            s_pull_rd |=> serial_reset_o
            || reg_rdata_o == {1'b0, row_pulldown_sel_o, 1'b0, column_pullup_sel_o})
            else $error("pull read back differs");
    a_rdata_idle:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("stray read data");
    a_serial_pulse_once:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            serial_reset_o |=> !serial_reset_o) else $error("serial reset too long");
    a_serial_after_rise:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            serial_reset_o |-> !$past(hw_shutdown_pin_n_i, 4)
            && $past(hw_shutdown_pin_n_i, 3)) else $error("serial reset without pin rise");
    a_pin_rise_reset:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            s_pin_rise |-> ##[1:6] serial_reset_o) else $error("no serial reset");
    a_pin_low_analog:
        assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
            !hw_shutdown_pin_n_i [*4] |-> !analog_en_o) else $error("analog on");
    a_pin_low_blank:
        assert property (@(posedge scan_clk_i) disable iff (!rst_n_i)
            !hw_shutdown_pin_n_i [*5] |-> column_current_sink_o == 39'h0
            && row_switch_out_o == 9'h0) else $error("matrix lit in shutdown");
    a_pin_low_nopull:
        assert property (@(posedge scan_clk_i) disable iff (!rst_n_i)
            !hw_shutdown_pin_n_i [*5] |-> column_pullup_en_o == 39'h0
            && row_pulldown_en_o == 9'h0) else $error("pull on in shutdown");
    a_pull_only_off:
        assert property (@(posedge scan_clk_i) disable iff (!rst_n_i)
            (column_current_sink_o & column_pullup_en_o) == 39'h0
            && (row_switch_out_o & row_pulldown_en_o) == 9'h0) else $error("pull on");
    a_one_row_only:
        assert property (@(posedge scan_clk_i) disable iff (!rst_n_i)
            $onehot0(row_switch_out_o)) else $error("two rows conduct");
endmodule
bind lmbs_top lmbs_checker u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scan_clk_i(scan_clk_i),
    .hw_shutdown_pin_n_i(hw_shutdown_pin_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .serial_reset_o(serial_reset_o),
    .analog_en_o(analog_en_o), .row_pulldown_sel_o(row_pulldown_sel_o),
    .column_pullup_sel_o(column_pullup_sel_o), .row_switch_out_o(row_switch_out_o),
    .column_current_sink_o(column_current_sink_o),
    .row_pulldown_en_o(row_pulldown_en_o), .column_pullup_en_o(column_pullup_en_o));
`default_nettype wire

// ===== tb/testbench.sv
/* Testbench: register sequences with expected values for lmbs_top.
   Assumes the host model and checker are compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
`include "lmbs_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    import lmbs_pkg::*;
    logic        core_clk, scan_clk, rst_n, pin_n, wr, rd, ser_rst, ana_en, cnt_on;
    lmbs_addr_t  addr;
    lmbs_byte_t  wdata, rdata, d;
    logic [2:0]  row_sel, col_sel;
    logic [8:0]  row_sw, row_pd;
    logic [38:0] sink, col_pu;
    int          n_fail, n_tests, cyc, c_first, c_last, c_row, c_pu;
    lmbs_host_model u_host (.core_clk_i(core_clk), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    lmbs_top u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .scan_clk_i(scan_clk),
        .hw_shutdown_pin_n_i(pin_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .serial_reset_o(ser_rst),
        .analog_en_o(ana_en), .row_pulldown_sel_o(row_sel),
        .column_pullup_sel_o(col_sel), .row_switch_out_o(row_sw),
        .column_current_sink_o(sink), .row_pulldown_en_o(row_pd),
        .column_pullup_en_o(col_pu));
    // Clocks: core 20 ns, scan 160 ns with its own phase
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        scan_clk = 1'b0;
        #7;
        forever #80 scan_clk = ~scan_clk;
    end
    // On-cycles of the first and last column, row 0 and column 0 pull in the window
    always @(posedge scan_clk) begin
        if (cnt_on) begin
            c_first += int'(sink[0]);
            c_last  += int'(sink[38]);
            c_row   += int'(row_sw[0]);
            c_pu    += int'(col_pu[0]);
        end
    end
    // Cut a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n  = 1'b0;
        pin_n  = 1'b1;
        cnt_on = 1'b0;
        repeat (3) @(posedge scan_clk);
        @(posedge core_clk);
        rst_n <= 1'b1;
        u_host.rd(`LMBS_OFF_PULL, d);
        `CHK("pull reset", 8'h55, d)
        u_host.rd(`LMBS_OFF_CONFIG, d);
        `CHK("config reset", 8'h00, d)
        u_host.rd(`LMBS_OFF_STATUS, d);
        `CHK("status soft off", 8'h02, d)
        u_host.wr(10'h300, 8'haa);
        u_host.rd(10'h300, d);
        `CHK("unmapped", 8'h00, d)
        u_host.wr(`LMBS_OFF_PULL, 8'hff);
        u_host.rd(`LMBS_OFF_PULL, d);
        `CHK("pull masked", 8'h77, d)
        `CHK("sel fields", 6'h3f, {row_sel, col_sel})
        u_host.wr(`LMBS_OFF_PWM_FIRST, 8'h04);
        u_host.wr(`LMBS_OFF_PWM_LAST, 8'hff);
        u_host.rd(`LMBS_OFF_PWM_LAST, d);
        `CHK("pwm in soft off", 8'hff, d)
        repeat (8) @(posedge scan_clk);
        @(negedge core_clk);
        `CHK("sinks soft off", 39'h0, sink)
        `CHK("rows soft off", 9'h0, row_sw)
        `CHK("col pulls", {39{1'b1}}, col_pu)
        `CHK("row pulls", 9'h1ff, row_pd)
        u_host.wr(`LMBS_OFF_PULL, 8'h00);
        repeat (8) @(posedge scan_clk);
        @(negedge core_clk);
        `CHK("no pulls", 48'h0, {col_pu, row_pd})
        u_host.wr(`LMBS_OFF_PULL, 8'h77);
        u_host.wr(`LMBS_OFF_CONFIG, 8'h01);
        repeat (8) @(posedge scan_clk);
        @(negedge scan_clk);
        cnt_on = 1'b1;
        repeat (2313) @(negedge scan_clk);
        cnt_on = 1'b0;
        `CHK("code 4 steps", 4, c_first)
        `CHK("code 255 steps", 255, c_last)
        `CHK("row 0 steps", 256, c_row)
        `CHK("col 0 pull steps", 2309, c_pu)
        u_host.wr(10'h001, 8'hff);
        u_host.wr(10'h002, 8'hff);
        u_host.breathe(10'h001, 1'b0);
        u_host.breathe(10'h002, 1'b1);
        u_host.rd(10'h001, d);
        `CHK("breath end", 8'h00, d)
        u_host.rd(10'h002, d);
        `CHK("fine breath end", 8'h00, d)
        @(posedge core_clk);
        pin_n <= 1'b0;
        repeat (8) @(posedge scan_clk);
        @(negedge core_clk);
        `CHK("analog off", 1'b0, ana_en)
        `CHK("sinks hw off", 39'h0, sink)
        `CHK("pulls hw off", 48'h0, {col_pu, row_pd})
        u_host.rd(`LMBS_OFF_STATUS, d);
        `CHK("status hw off", 8'h01, d)
        u_host.wr(`LMBS_OFF_PWM_FIRST, 8'h10);
        u_host.rd(`LMBS_OFF_PWM_FIRST, d);
        `CHK("pwm in hw off", 8'h10, d)
        @(posedge core_clk);
        pin_n <= 1'b1;
        for (int i = 0; i < 10 && ser_rst !== 1'b1; i++) @(negedge core_clk);
        `CHK("serial reset", 1'b1, ser_rst)
        @(negedge core_clk);
        `CHK("serial reset once", 1'b0, ser_rst)
        repeat (2) @(negedge core_clk);
        `CHK("analog on", 1'b1, ana_en)
        u_host.rd(`LMBS_OFF_PWM_LAST, d);
        `CHK("pwm kept", 8'hff, d)
        u_host.rd(`LMBS_OFF_CONFIG, d);
        `CHK("config kept", 8'h01, d)
        u_host.rd(`LMBS_OFF_PULL, d);
        `CHK("pull kept", 8'h77, d)
        tally_and_finish();
    end
endmodule
`default_nettype wire
